// ==== design/upscc_defines.svh ====
// offsets, field positions, reset values and timing counts of the clock control block
`ifndef UPSCC_DEFINES_SVH
`define UPSCC_DEFINES_SVH

// special function register addresses
`define UPSCC_ADDR_PLL_CONTROL     8'hA3
`define UPSCC_ADDR_PLL_DIVIDER     8'hA4
`define UPSCC_ADDR_SPI_CLOCK_CTRL  8'hAF

// pll_control fields
`define UPSCC_BIT_EXT_BYPASS       2
`define UPSCC_BIT_PLL_ENABLE       1
`define UPSCC_BIT_LOCK_FLAG        0

// pll_divider fields
`define UPSCC_FB_DIV_MSB           7
`define UPSCC_FB_DIV_LSB           4
`define UPSCC_REF_DIV_MSB          3
`define UPSCC_REF_DIV_LSB          0

// spi_clock_control fields
`define UPSCC_BIT_SPI_PRESCALE     0

// reset values
`define UPSCC_RST_PLL_CONTROL      8'h00
`define UPSCC_RST_PLL_DIVIDER      8'h00
`define UPSCC_RST_SPI_CLOCK_CTRL   8'h00
`define UPSCC_UNMAPPED_READ        8'h00

// clock periods per spi peripheral cycle
`define UPSCC_SPI_PERIODS_FAST     4'h6
`define UPSCC_SPI_PERIODS_SLOW     4'hC

// reference cycles the lock model waits after enable or restart
`define UPSCC_LOCK_SETTLE_CYCLES   5'h10

`endif

// ==== design/upscc_pkg.sv ====
// shared types of the clock control block
package upscc_pkg;

  // lock model progress
  typedef enum logic [1:0] {
    LOCK_IDLE,
    LOCK_SETTLE,
    LOCK_LOCKED
  } upscc_lock_state_t;

endpackage : upscc_pkg

// ==== design/upscc_lock_if.sv ====
// carrier between the register file and the pll lock model
`timescale 1ns/1ps

interface upscc_lock_if;
  logic pllEnable;   // pll clock generation requested
  logic restart;     // one-cycle pulse: divider settings changed
  logic locked;      // lock indicator from the model

  modport ctrl  (output pllEnable, output restart, input  locked);
  modport model (input  pllEnable, input  restart, output locked);
endinterface : upscc_lock_if

// ==== design/upscc_lock_model.sv ====
// digital stand-in for the analog pll lock detector
`timescale 1ns/1ps
`include "upscc_defines.svh"

module upscc_lock_model (
  input  wire logic        clk,
  input  wire logic        rst,
  upscc_lock_if.model      lk
);

  upscc_pkg::upscc_lock_state_t state_q;
  logic [4:0]                   settleCnt_q;
  logic                         locked_q;

  assign lk.locked = locked_q;

  // ************************************************************
  // settle sequence: count reference cycles, then declare lock
  // ************************************************************
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_q     <= upscc_pkg::LOCK_IDLE;
      settleCnt_q <= 5'h00;
      locked_q    <= 1'b0;
    end else if (!lk.pllEnable) begin
      state_q     <= upscc_pkg::LOCK_IDLE;      // disable drops lock at once
      settleCnt_q <= 5'h00;
      locked_q    <= 1'b0;
    end else if (lk.restart) begin
      state_q     <= upscc_pkg::LOCK_SETTLE;    // divider change restarts settling
      settleCnt_q <= 5'h00;
      locked_q    <= 1'b0;
    end else begin
      case (state_q)
        upscc_pkg::LOCK_IDLE: begin
          state_q     <= upscc_pkg::LOCK_SETTLE;
          settleCnt_q <= 5'h00;
        end
        upscc_pkg::LOCK_SETTLE: begin
          if (settleCnt_q == `UPSCC_LOCK_SETTLE_CYCLES - 5'h01) begin
            state_q  <= upscc_pkg::LOCK_LOCKED;
            locked_q <= 1'b1;
          end else begin
            settleCnt_q <= settleCnt_q + 5'h01;
          end
        end
        upscc_pkg::LOCK_LOCKED: begin
          locked_q <= 1'b1;
        end
        default: begin
          state_q  <= upscc_pkg::LOCK_IDLE;
          locked_q <= 1'b0;
        end
      endcase
    end
  end

  // lock never rises unless enable was high 16 cycles before and 1 cycle before
  chk_lock_settle_time: assert property (
    @(posedge clk) disable iff (rst)
    $rose(locked_q) |-> ($past(lk.pllEnable, 16) && $past(lk.pllEnable, 1)))
    else $error("lock rose before the settle time elapsed");

endmodule : upscc_lock_model

// ==== design/upscc_clock_control.sv ====
// special function registers for pll control, pll dividers and spi prescale
`timescale 1ns/1ps
`include "upscc_defines.svh"

module upscc_clock_control (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic [7:0] sfrAddr,
  input  wire logic       sfrWr,
  input  wire logic [7:0] sfrWdata,
  input  wire logic       sfrRd,
  output logic      [7:0] sfrRdata,
  input  wire logic       coreDoubleSpeedFlag,
  output logic            pllEnable,
  output logic            externalClockBypass,
  output logic            oscEnable,
  output logic            usbClkFromPll,
  output logic      [3:0] feedbackDividerField,
  output logic      [3:0] referenceDividerField,
  output logic            pllLockFlag,
  output logic            spiPeriphTick
);

  // ************************************************************
  // decode and helpers
  // ************************************************************
  logic       selPllCtl;
  logic       selPllDiv;
  logic       selSpiCtl;
  logic       spiPrescaleSelect_q;
  logic [7:0] pllDivider_q;
  logic       pllEnable_q;
  logic       extBypass_q;
  logic       oscEnable_q;
  logic       usbClkFromPll_q;
  logic       lockFlag_q;
  logic [7:0] rdata_q;
  logic [3:0] spiCnt_q;
  logic       spiTick_q;
  logic [3:0] spiPeriod;

  upscc_lock_if lockBus ();

  // clocks per spi peripheral cycle from the select bit and the core speed flag
  function automatic logic [3:0] spiPeriodOf(input logic dbl, input logic sel);
    if (dbl && !sel) begin
      spiPeriodOf = `UPSCC_SPI_PERIODS_FAST;
    end else begin
      spiPeriodOf = `UPSCC_SPI_PERIODS_SLOW;   // select ignored at normal speed
    end
  endfunction : spiPeriodOf

  // full eight-bit compare so no alias of the register appears elsewhere
  assign selPllCtl = (sfrAddr == `UPSCC_ADDR_PLL_CONTROL);
  assign selPllDiv = (sfrAddr == `UPSCC_ADDR_PLL_DIVIDER);
  assign selSpiCtl = (sfrAddr == `UPSCC_ADDR_SPI_CLOCK_CTRL);
  assign spiPeriod = spiPeriodOf(coreDoubleSpeedFlag, spiPrescaleSelect_q);

  // ************************************************************
  // pll control register
  // ************************************************************
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pllEnable_q <= 1'b0;
      extBypass_q <= 1'b0;
    end else if (sfrWr && selPllCtl) begin
      pllEnable_q <= sfrWdata[`UPSCC_BIT_PLL_ENABLE];
      extBypass_q <= sfrWdata[`UPSCC_BIT_EXT_BYPASS];
    end
  end

  // clock routing follows the bypass bit one cycle later
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      oscEnable_q     <= 1'b1;
      usbClkFromPll_q <= 1'b1;
    end else begin
      oscEnable_q     <= ~extBypass_q;         // crystal stopped in bypass
      usbClkFromPll_q <= ~extBypass_q;
    end
  end

  // ************************************************************
  // pll divider register and lock model
  // ************************************************************
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pllDivider_q <= `UPSCC_RST_PLL_DIVIDER;
    end else if (sfrWr && selPllDiv) begin
      pllDivider_q <= sfrWdata;
    end
  end

  // rewriting the same divider value does not disturb an existing lock
  assign lockBus.pllEnable = pllEnable_q;
  assign lockBus.restart   = sfrWr && selPllDiv && (sfrWdata != pllDivider_q);

  upscc_lock_model upscc_lock_model_inst (
    .clk (clk),
    .rst (rst),
    .lk  (lockBus.model)
  );

  // lock flag has no write path at all
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      lockFlag_q <= 1'b0;
    end else begin
      lockFlag_q <= lockBus.locked & pllEnable_q;
    end
  end

  // ************************************************************
  // spi clock control and prescaler
  // ************************************************************
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      spiPrescaleSelect_q <= 1'b0;
    end else if (sfrWr && selSpiCtl) begin
      spiPrescaleSelect_q <= sfrWdata[`UPSCC_BIT_SPI_PRESCALE];
    end
  end

  // a period shrink mid-count wraps at once instead of overrunning
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      spiCnt_q  <= 4'h0;
      spiTick_q <= 1'b0;
    end else if (spiCnt_q >= spiPeriod - 4'h1) begin
      spiCnt_q  <= 4'h0;
      spiTick_q <= 1'b1;
    end else begin
      spiCnt_q  <= spiCnt_q + 4'h1;
      spiTick_q <= 1'b0;
    end
  end

  // ************************************************************
  // read data
  // ************************************************************
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdata_q <= `UPSCC_UNMAPPED_READ;
    end else if (sfrRd) begin
      if (selPllCtl) begin
        rdata_q <= {5'h00, extBypass_q, pllEnable_q, lockFlag_q};
      end else if (selPllDiv) begin
        rdata_q <= pllDivider_q;
      end else if (selSpiCtl) begin
        rdata_q <= {7'h00, spiPrescaleSelect_q};
      end else begin
        rdata_q <= `UPSCC_UNMAPPED_READ;
      end
    end
  end

  assign sfrRdata              = rdata_q;
  assign pllEnable             = pllEnable_q;
  assign externalClockBypass   = extBypass_q;
  assign oscEnable             = oscEnable_q;
  assign usbClkFromPll         = usbClkFromPll_q;
  assign feedbackDividerField  = pllDivider_q[`UPSCC_FB_DIV_MSB:`UPSCC_FB_DIV_LSB];
  assign referenceDividerField = pllDivider_q[`UPSCC_REF_DIV_MSB:`UPSCC_REF_DIV_LSB];
  assign pllLockFlag           = lockFlag_q;
  assign spiPeriphTick         = spiTick_q;

  // ************************************************************
  // checks
  // ************************************************************
  logic [3:0] sinceTick_q;
  logic [3:0] modeHeld_q;
  logic       modeNow;
  logic       modePrev_q;

  // helper: cycles since last tick and how long the effective mode held
  assign modeNow = coreDoubleSpeedFlag & ~spiPrescaleSelect_q;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sinceTick_q <= 4'h0;
      modeHeld_q  <= 4'h0;
      modePrev_q  <= 1'b0;
    end else begin
      sinceTick_q <= spiTick_q ? 4'h1 : sinceTick_q + 4'h1;
      modePrev_q  <= modeNow;
      modeHeld_q  <= (modeNow != modePrev_q) ? 4'h0 : ((modeHeld_q == 4'hF) ? 4'hF
                                                       : modeHeld_q + 4'h1);
    end
  end

  chk_spi_fast_period: assert property (
    @(posedge clk) disable iff (rst)
    (spiTick_q && modeNow && modeHeld_q >= 4'hD && $past(spiTick_q, 6)) |-> sinceTick_q == 4'h6)
    else $error("spi cycle not 6 clocks in fast mode");

  // judged looking back, so a mode change after the tick cannot raise a false alarm
  chk_spi_slow_period: assert property (
    @(posedge clk) disable iff (rst)
    (spiTick_q && !modeNow && modeHeld_q >= 4'hD) |-> sinceTick_q == 4'hC)
    else $error("spi cycle not 12 clocks with select set or core flag low");

  chk_reserved_zero: assert property (
    @(posedge clk) disable iff (rst)
    (sfrRd && (selPllCtl || selSpiCtl)) |=> (rdata_q[7:3] == 5'h00)
      && (!$past(selSpiCtl) || rdata_q[7:1] == 7'h00))
    else $error("reserved bits read as one");

  chk_bypass_route: assert property (
    @(posedge clk) disable iff (rst)
    (sfrWr && selPllCtl && sfrWdata[2]) |=> ##1 (!oscEnable_q && !usbClkFromPll_q))
    else $error("bypass did not stop oscillator or move usb clock");

  chk_pll_route: assert property (
    @(posedge clk) disable iff (rst)
    (sfrWr && selPllCtl && !sfrWdata[2]) |=> ##1 (oscEnable_q && usbClkFromPll_q))
    else $error("clearing bypass did not restore pll routing");

  chk_enable_write: assert property (
    @(posedge clk) disable iff (rst)
    (sfrWr && selPllCtl) |=> pllEnable_q == $past(sfrWdata[1]))
    else $error("pll enable did not take the written value");

  chk_lock_drop: assert property (
    @(posedge clk) disable iff (rst)
    (sfrWr && selPllCtl && !sfrWdata[1]) |=> ##[0:2] !lockFlag_q)
    else $error("lock flag survived pll disable");

  chk_divider_fields: assert property (
    @(posedge clk) disable iff (rst)
    (sfrWr && selPllDiv) |=> (feedbackDividerField == $past(sfrWdata[7:4]))
      && (referenceDividerField == $past(sfrWdata[3:0])))
    else $error("divider fields not stored in place");

  chk_reset_values: assert property (
    @(posedge clk)
    $past(rst) |-> (pllDivider_q == 8'h00 && !pllEnable_q && !extBypass_q
      && !spiPrescaleSelect_q && !lockFlag_q))
    else $error("register not zero after reset");

endmodule : upscc_clock_control

// ==== sim/tb_usb_pll_and_spi_clock_control.sv ====
// self-checking bench for the pll and spi clock control registers
`timescale 1ns/1ps

module tb_usb_pll_and_spi_clock_control;
  // ************************************
  // signals and design instance
  // ************************************
  logic       clk;
  logic       rst;
  logic [7:0] sfrAddr;
  logic       sfrWr;
  logic [7:0] sfrWdata;
  logic       sfrRd;
  logic [7:0] sfrRdata;
  logic       coreDoubleSpeedFlag;
  logic       pllEnable;
  logic       externalClockBypass;
  logic       oscEnable;
  logic       usbClkFromPll;
  logic [3:0] feedbackDividerField;
  logic [3:0] referenceDividerField;
  logic       pllLockFlag;
  logic       spiPeriphTick;
  int         miscompares    = 0;
  int         samplesChecked = 0;
  int         cycleCount     = 0;

  upscc_clock_control upscc_clock_control_inst (
    .clk                   (clk),
    .rst                   (rst),
    .sfrAddr               (sfrAddr),
    .sfrWr                 (sfrWr),
    .sfrWdata              (sfrWdata),
    .sfrRd                 (sfrRd),
    .sfrRdata              (sfrRdata),
    .coreDoubleSpeedFlag   (coreDoubleSpeedFlag),
    .pllEnable             (pllEnable),
    .externalClockBypass   (externalClockBypass),
    .oscEnable             (oscEnable),
    .usbClkFromPll         (usbClkFromPll),
    .feedbackDividerField  (feedbackDividerField),
    .referenceDividerField (referenceDividerField),
    .pllLockFlag           (pllLockFlag),
    .spiPeriphTick         (spiPeriphTick)
  );

  // 100 ns period
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // whole run needs well under a thousand cycles; the ceiling leaves wide margin
  always @(posedge clk) begin
    cycleCount++;
    if (cycleCount == 6000) begin
      miscompares++;
      print_verdict();
    end
  end

  // ************************************
  // shared tasks
  // ************************************
  // inputs move 1 ns after the rising edge so no race with the sampling edge
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : step

  task automatic check(input string name, input logic [7:0] exp, input logic [7:0] got);
    samplesChecked++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", name, exp, got);
    end
  endtask : check

  // an idle edge follows each strobe so the next request never reassigns it at once
  task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
    sfrAddr  = a;
    sfrWdata = d;
    sfrWr    = 1'b1;
    step(1);
    sfrWr    = 1'b0;
    step(1);
  endtask : write_reg

  // read data is registered and stands until the next read strobe
  task automatic read_check(input string name, input logic [7:0] a, input logic [7:0] exp);
    sfrAddr = a;
    sfrRd   = 1'b1;
    step(1);
    sfrRd   = 1'b0;
    step(1);
    check(name, exp, sfrRdata);
  endtask : read_check

  task automatic wait_lock(output int n);
    n = 0;
    while (pllLockFlag !== 1'b1 && n < 40) begin
      step(1);
      n++;
    end
  endtask : wait_lock

  // skips to the next tick, then counts clocks up to the following one
  task automatic measure(output int p);
    int n;
    n = 0;
    while (spiPeriphTick !== 1'b1 && n < 30) begin
      step(1);
      n++;
    end
    p = 0;
    do begin
      step(1);
      p++;
    end while (spiPeriphTick !== 1'b1 && p < 30);
  endtask : measure

  // ************************************
  // scenarios
  // ************************************
  task automatic test_reset();
    read_check("pll_control", 8'hA3, 8'h00);
    read_check("pll_divider", 8'hA4, 8'h00);
    read_check("spi_clock_control", 8'hAF, 8'h00);
    check("oscEnable", 8'h01, {7'h00, oscEnable});
    check("usbClkFromPll", 8'h01, {7'h00, usbClkFromPll});
    check("pllEnable", 8'h00, {7'h00, pllEnable});
  endtask : test_reset

  // reserved bits are only ever written as zero; the lock bit write must be ignored
  task automatic test_fields();
    write_reg(8'hA4, 8'h5A);
    check("feedbackDividerField", 8'h05, {4'h0, feedbackDividerField});
    check("referenceDividerField", 8'h0A, {4'h0, referenceDividerField});
    read_check("pll_divider", 8'hA4, 8'h5A);
    write_reg(8'hAF, 8'h01);
    read_check("spi_clock_control", 8'hAF, 8'h01);
    write_reg(8'hA5, 8'h77);
    read_check("unmapped", 8'hA5, 8'h00);
    write_reg(8'hA3, 8'h01);
    read_check("pll_control", 8'hA3, 8'h00);
    write_reg(8'hAF, 8'h00);
  endtask : test_fields

  task automatic test_bypass();
    write_reg(8'hA3, 8'h04);
    check("externalClockBypass", 8'h01, {7'h00, externalClockBypass});
    step(1);
    check("oscEnable", 8'h00, {7'h00, oscEnable});
    check("usbClkFromPll", 8'h00, {7'h00, usbClkFromPll});
    read_check("pll_control", 8'hA3, 8'h04);
    write_reg(8'hA3, 8'h00);
    step(1);
    check("oscEnable", 8'h01, {7'h00, oscEnable});
    check("usbClkFromPll", 8'h01, {7'h00, usbClkFromPll});
  endtask : test_bypass

  task automatic test_lock();
    int n;
    write_reg(8'hA4, 8'h30);
    write_reg(8'hA3, 8'h02);
    check("pllEnable", 8'h01, {7'h00, pllEnable});
    wait_lock(n);
    // settle takes 16 cycles plus pipeline stages
    check("lock delay ok", 8'h01, {7'h00, (n >= 16 && n <= 24)});
    read_check("pll_control", 8'hA3, 8'h03);
    write_reg(8'hA4, 8'h31);
    step(2);
    check("lock after divider change", 8'h00, {7'h00, pllLockFlag});
    wait_lock(n);
    check("relock", 8'h01, {7'h00, pllLockFlag});
    write_reg(8'hA4, 8'h31);
    step(2);
    check("lock after same divider", 8'h01, {7'h00, pllLockFlag});
    write_reg(8'hA3, 8'h00);
    step(2);
    check("lock after disable", 8'h00, {7'h00, pllLockFlag});
    read_check("pll_control", 8'hA3, 8'h00);
  endtask : test_lock

  // every combination of the core flag and the prescale select; four periods per
  // mode so the steady-period checks inside the design also see each mode
  task automatic test_spi();
    int p;
    logic [7:0] exp;
    for (int i = 0; i < 4; i++) begin
      write_reg(8'hAF, {7'h00, i[0]});
      coreDoubleSpeedFlag = i[1];
      exp = (i[1] && !i[0]) ? 8'h06 : 8'h0C;
      repeat (4) measure(p);
      check("spi period", exp, p[7:0]);
    end
  endtask : test_spi

  task automatic print_verdict();
    if (miscompares == 0 && samplesChecked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : print_verdict

  // ************************************
  // main sequence
  // ************************************
  initial begin
    rst                 = 1'b1;
    sfrAddr             = 8'h00;
    sfrWr               = 1'b0;
    sfrWdata            = 8'h00;
    sfrRd               = 1'b0;
    coreDoubleSpeedFlag = 1'b0;
    step(20);
    rst = 1'b0;
    test_reset();
    test_fields();
    test_bypass();
    test_lock();
    test_spi();
    print_verdict();
  end
endmodule : tb_usb_pll_and_spi_clock_control
